//--- core/ppfe_map.svh
/*
  Constants of the parallel programming front end: command codes,
  action-select codes, page geometry and operation times.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef PPFE_MAP_SVH
`define PPFE_MAP_SVH

// Command byte codes
`define PPFE_CMD_NOP         8'h00
`define PPFE_CMD_CHIP_ERASE  8'h80
`define PPFE_CMD_WRITE_FLASH 8'h10

// Action-select codes, high bit first
`define PPFE_ACT_ADDR 2'h0
`define PPFE_ACT_DATA 2'h1
`define PPFE_ACT_CMD  2'h2

// Page geometry: 32 words per page, 128 pages
`define PPFE_WORD_BITS 5
`define PPFE_PAGE_BITS 7
`define PPFE_PAGE_WORDS 32
`define PPFE_LAST_WORD 5'h1F

// Operation times in microseconds and the clock rate in MHz
`define PPFE_CLK_MHZ        40
`define PPFE_PAGE_TIME_US   3700
`define PPFE_ERASE_TIME_US  7500

// Reset values
`define PPFE_RST_BYTE 8'h00
`define PPFE_RST_WORD 16'h0000

`endif

//--- core/ppfe_pkg.sv
/*
  Types of the parallel programming front end.
  Assumes the constants header sits beside it in core/.
*/
`include "ppfe_map.svh"

package ppfe_pkg;

    // Operation sequencer states
    typedef enum logic [2:0] {
        PPFE_IDLE     = 3'b000,
        PPFE_PROG_OUT = 3'b001,
        PPFE_PROG_WT  = 3'b010,
        PPFE_ERASE_WT = 3'b011,
        PPFE_LOCK_CLR = 3'b100
    } ppfe_state_t;

    typedef logic [15:0] ppfe_word_t;

endpackage

//--- core/ppfe_top.sv
/*
  Parallel programming front end: command, address and data loading
  from the programmer's pins, the flash page buffer, page write and
  chip erase sequencing, and the ready/busy flag.
  Assumes the chip is already in programming mode, that all pins are
  asynchronous to mclk and stay stable for several mclk periods, and
  that the flash and EEPROM arrays act on the strobes driven here.
*/
`timescale 1ns/1ps
`include "ppfe_map.svh"

// Overview of operation
// - Command and address held until reloaded
// - Erase clears flash, EEPROM, locks; fuses kept
// - Locks cleared only after flash erase ends
// - EEPROM kept when keep fuse is programmed
// - Action 10 plus strobe loads command byte
// - Erase command plus write pulse starts erase
// - Command 10h enables flash page writing
// - Action 00 loads address low or high
// - Action 01 loads data low or high
// - Page latch stores data word into buffer
// - Whole page programmed from buffer at once
// - Low bits pick word, upper bits pick page
// - Write pulse with byte select low programs page
// - Ready flag low while busy, high otherwise
// - No-operation command makes a write pulse do nothing
module ppfe_top
    import ppfe_pkg::*;
#(
    parameter int PAGE_CYCLES  = `PPFE_PAGE_TIME_US * `PPFE_CLK_MHZ,
    parameter int ERASE_CYCLES = `PPFE_ERASE_TIME_US * `PPFE_CLK_MHZ
)
(
    // Clock, reset and clock enable
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // Programmer pins
    input  wire logic        loadStrobePin,
    input  wire logic        actionSelectHi,
    input  wire logic        actionSelectLo,
    input  wire logic        byteSelectOne,
    input  wire logic        pageLatchStrobe,
    input  wire logic        writeStrobe_n,
    input  wire logic [7:0]  dataIn,
    // Fuse level
    input  wire logic        eepromKeepFuse,
    // Status and loaded values
    output logic             writeDoneFlag,
    output logic [7:0]       commandByte,
    output logic [15:0]      addressWord,
    // Flash page programming port
    output logic             progWordWe,
    output logic [11:0]      progWordAddr,
    output logic [15:0]      progWordData,
    // Erase strobes
    output logic             flashEraseStrobe,
    output logic             eepromEraseStrobe,
    output logic             lockClearStrobe
);

    localparam int PIN_W = 15;

    // Pin synchroniser and edge history
    logic [PIN_W-1:0] pinMeta;
    logic [PIN_W-1:0] pinSync;
    logic [PIN_W-1:0] pinLast;
    logic [PIN_W-1:0] pinRaw;

    assign pinRaw = {eepromKeepFuse, dataIn, writeStrobe_n, pageLatchStrobe,
                     byteSelectOne, actionSelectHi, actionSelectLo, loadStrobePin};

    // Decoded synchronised pins
    logic       sLoad;
    logic [1:0] sAction;
    logic       sByteSel;
    logic       sLatch;
    logic       sWrite_n;
    logic [7:0] sData;
    logic       sKeep;
    logic       loadRise;
    logic       latchRise;
    logic       writeFall;

    assign sLoad    = pinSync[0];
    assign sAction  = {pinSync[2], pinSync[1]};
    assign sByteSel = pinSync[3];
    assign sLatch   = pinSync[4];
    assign sWrite_n = pinSync[5];
    assign sData    = pinSync[13:6];
    assign sKeep    = pinSync[14];

    // Edges are taken between the second stage and the history stage only
    assign loadRise  = sLoad & ~pinLast[0];
    assign latchRise = sLatch & ~pinLast[4];
    assign writeFall = ~sWrite_n & pinLast[5];

    // Loaded registers
    logic [7:0]  dataLo;
    logic [7:0]  dataHi;
    logic [7:0]  next_commandByte;
    logic [15:0] next_addressWord;
    logic [7:0]  next_dataLo;
    logic [7:0]  next_dataHi;

    // Sequencer state
    ppfe_state_t state;
    ppfe_state_t next_state;
    logic [18:0] waitCount;
    logic [18:0] next_waitCount;
    logic [4:0]  wordIdx;
    logic [4:0]  next_wordIdx;
    logic [6:0]  pageNum;
    logic [6:0]  next_pageNum;
    logic        next_writeDoneFlag;
    logic        next_progWordWe;
    logic [11:0] next_progWordAddr;
    logic [15:0] next_progWordData;
    logic        next_flashEraseStrobe;
    logic        next_eepromEraseStrobe;
    logic        next_lockClearStrobe;

    // Page buffer
    ppfe_word_t pageBuf [`PPFE_PAGE_WORDS];
    logic       bufWe;
    logic [4:0] bufIdx;
    logic       flashWriteOn;
    logic       idle;

    assign flashWriteOn = (commandByte == `PPFE_CMD_WRITE_FLASH);
    assign idle         = (state == PPFE_IDLE);

    // Pins are asynchronous, so every one passes two flops first
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinMeta <= '0;
            pinSync <= '0;
            pinLast <= '0;
        end
        else if (clkEn)
        begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
            pinLast <= pinSync;
        end
    end

    // Command, address and data loading on the load strobe
    always_comb
    begin
        next_commandByte = commandByte;
        next_addressWord = addressWord;
        next_dataLo      = dataLo;
        next_dataHi      = dataHi;
        if (loadRise)
        begin
            unique case (sAction)
                `PPFE_ACT_CMD:
                begin
                    next_commandByte = sData;
                end
                `PPFE_ACT_ADDR:
                begin
                    if (sByteSel)
                        next_addressWord[15:8] = sData;
                    else
                        next_addressWord[7:0] = sData;
                end
                `PPFE_ACT_DATA:
                begin
                    if (sByteSel)
                        next_dataHi = sData;
                    else
                        next_dataLo = sData;
                end
                default:
                begin
                    next_dataLo = dataLo;       // Idle action does nothing
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            commandByte <= `PPFE_RST_BYTE;
            addressWord <= `PPFE_RST_WORD;
            dataLo      <= `PPFE_RST_BYTE;
            dataHi      <= `PPFE_RST_BYTE;
        end
        else if (clkEn)
        begin
            commandByte <= next_commandByte;
            addressWord <= next_addressWord;
            dataLo      <= next_dataLo;
            dataHi      <= next_dataHi;
        end
    end

    // Buffer latch; refused while a page is being sent out, as it is read then
    always_comb
    begin
        bufWe  = latchRise & sByteSel & flashWriteOn & idle;
        bufIdx = addressWord[`PPFE_WORD_BITS-1:0];
    end

    // Buffer contents survive reset; all 32 words are sent out, written or stale
    always_ff @(posedge mclk)
    begin
        if (clkEn && bufWe)
            pageBuf[bufIdx] <= {dataHi, dataLo};
    end

    // Operation sequencer: page write and chip erase
    always_comb
    begin
        next_state             = state;
        next_waitCount         = waitCount;
        next_wordIdx           = wordIdx;
        next_pageNum           = pageNum;
        next_writeDoneFlag     = writeDoneFlag;
        next_progWordWe        = 1'b0;
        next_progWordAddr      = progWordAddr;
        next_progWordData      = progWordData;
        next_flashEraseStrobe  = 1'b0;
        next_eepromEraseStrobe = 1'b0;
        next_lockClearStrobe   = 1'b0;
        unique case (state)
            PPFE_IDLE:
            begin
                next_writeDoneFlag = 1'b1;
                // A write pulse is only seen here, so busy ignores it
                if (writeFall)
                begin
                    if (commandByte == `PPFE_CMD_CHIP_ERASE)
                    begin
                        next_state             = PPFE_ERASE_WT;
                        next_writeDoneFlag     = 1'b0;
                        next_waitCount         = 19'(ERASE_CYCLES - 1);
                        next_flashEraseStrobe  = 1'b1;
                        next_eepromEraseStrobe = ~sKeep;
                    end
                    else if (flashWriteOn && !sByteSel)
                    begin
                        next_state         = PPFE_PROG_OUT;
                        next_writeDoneFlag = 1'b0;
                        next_wordIdx       = 5'h00;
                        // Page from low four bits of high byte plus top three bits of low byte
                        next_pageNum = {addressWord[11:8],
                                        addressWord[7:`PPFE_WORD_BITS]};
                    end
                end
            end
            PPFE_PROG_OUT:
            begin
                // Whole buffer goes out word by word to the array
                next_progWordWe   = 1'b1;
                next_progWordAddr = {pageNum, wordIdx};
                next_progWordData = pageBuf[wordIdx];
                next_wordIdx      = wordIdx + 5'h01;
                if (wordIdx == `PPFE_LAST_WORD)
                begin
                    next_state     = PPFE_PROG_WT;
                    next_waitCount = 19'(PAGE_CYCLES - `PPFE_PAGE_WORDS - 1);
                end
            end
            PPFE_PROG_WT:
            begin
                next_waitCount = waitCount - 19'h00001;
                if (waitCount == 19'h00000)
                begin
                    next_state         = PPFE_IDLE;
                    next_writeDoneFlag = 1'b1;
                end
            end
            PPFE_ERASE_WT:
            begin
                next_waitCount = waitCount - 19'h00001;
                if (waitCount == 19'h00000)
                    next_state = PPFE_LOCK_CLR;
            end
            PPFE_LOCK_CLR:
            begin
                // Locks stay set until the flash erase time has run out
                next_lockClearStrobe = 1'b1;
                next_state           = PPFE_IDLE;
                next_writeDoneFlag   = 1'b1;
            end
            default:
            begin
                next_state         = PPFE_IDLE;
                next_writeDoneFlag = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state             <= PPFE_IDLE;
            waitCount         <= 19'h00000;
            wordIdx           <= 5'h00;
            pageNum           <= 7'h00;
            writeDoneFlag     <= 1'b1;
            progWordWe        <= 1'b0;
            progWordAddr      <= 12'h000;
            progWordData      <= `PPFE_RST_WORD;
            flashEraseStrobe  <= 1'b0;
            eepromEraseStrobe <= 1'b0;
            lockClearStrobe   <= 1'b0;
        end
        else if (clkEn)
        begin
            state             <= next_state;
            waitCount         <= next_waitCount;
            wordIdx           <= next_wordIdx;
            pageNum           <= next_pageNum;
            writeDoneFlag     <= next_writeDoneFlag;
            progWordWe        <= next_progWordWe;
            progWordAddr      <= next_progWordAddr;
            progWordData      <= next_progWordData;
            flashEraseStrobe  <= next_flashEraseStrobe;
            eepromEraseStrobe <= next_eepromEraseStrobe;
            lockClearStrobe   <= next_lockClearStrobe;
        end
    end

endmodule

//--- bench/ppfe_properties.sv
/*
  Checker of the front end's status, erase and page write ports.
  Assumes a bind to ppfe_top with its two count parameters handed on.
*/
`timescale 1ns/1ps
module ppfe_checker
    import ppfe_pkg::*;
#(
    parameter int PAGE_CYCLES  = 64,
    parameter int ERASE_CYCLES = 40
)
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Fuse and status
    input wire logic        eepromKeepFuse,
    input wire logic        writeDoneFlag,
    input wire logic [7:0]  commandByte,
    input wire logic [15:0] addressWord,
    // Page programming and erase
    input wire logic        progWordWe,
    input wire logic [11:0] progWordAddr,
    input wire logic        flashEraseStrobe,
    input wire logic        eepromEraseStrobe,
    input wire logic        lockClearStrobe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    int         eraseCnt;
    logic [5:0] weCnt;

    // Busy cycles since erase start, and length of the word burst
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eraseCnt <= 0;
            weCnt <= 6'h00;
        end
        else
        begin
            eraseCnt <= flashEraseStrobe ? 1 : eraseCnt + (writeDoneFlag ? 0 : 1);
            weCnt <= progWordWe ? weCnt + 6'h01 : 6'h00;
        end
    end

    property p_erase_start;
        flashEraseStrobe |-> commandByte == 8'h80 && $fell(writeDoneFlag) ##1 !flashEraseStrobe;
    endproperty
    a_erase_start: assert property (p_erase_start) else $error("erase start wrong");
    property p_eeprom_pair;
        eepromEraseStrobe |-> flashEraseStrobe;
    endproperty
    a_eeprom_pair: assert property (p_eeprom_pair) else $error("lone eeprom erase");
    property p_eeprom_keep;
        flashEraseStrobe |-> eepromEraseStrobe == !$past(eepromKeepFuse, 3);
    endproperty
    a_eeprom_keep: assert property (p_eeprom_keep) else $error("keep fuse ignored");
    property p_lock_late;
        lockClearStrobe |-> eraseCnt >= ERASE_CYCLES && writeDoneFlag;
    endproperty
    a_lock_late: assert property (p_lock_late) else $error("lock clear early");
    property p_busy_ignore;
        !$past(writeDoneFlag) |-> !flashEraseStrobe;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("erase while busy");
    property p_word_first;
        $rose(progWordWe) |-> progWordAddr[4:0] == 5'h00 && $past(!writeDoneFlag) && commandByte == 8'h10;
    endproperty
    a_word_first: assert property (p_word_first) else $error("burst start wrong");
    property p_word_step;
        progWordWe && $past(progWordWe) |-> progWordAddr == $past(progWordAddr) + 12'h001;
    endproperty
    a_word_step: assert property (p_word_step) else $error("word step wrong");
    property p_page_bits;
        progWordWe |-> progWordAddr[11:5] == addressWord[11:5] && !writeDoneFlag;
    endproperty
    a_page_bits: assert property (p_page_bits) else $error("page number wrong");
    property p_burst_len;
        $fell(progWordWe) |-> weCnt == 6'h20;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst length wrong");
    property p_held;
        !writeDoneFlag && !$past(writeDoneFlag) |-> $stable(commandByte) && $stable(addressWord);
    endproperty
    a_held: assert property (p_held) else $error("loaded value changed");
    property p_nop_quiet;
        $fell(writeDoneFlag) |-> commandByte inside {8'h10, 8'h80};
    endproperty
    a_nop_quiet: assert property (p_nop_quiet) else $error("busy on other command");

    // Main scenarios reached
    c_lock: cover property (lockClearStrobe);
    c_burst: cover property ($fell(progWordWe));
    c_eeprom: cover property (eepromEraseStrobe);
endmodule

bind ppfe_top ppfe_checker #(.PAGE_CYCLES(PAGE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) chk (
    .mclk(mclk), .rst_n(rst_n), .eepromKeepFuse(eepromKeepFuse), .writeDoneFlag(writeDoneFlag),
    .commandByte(commandByte), .addressWord(addressWord), .progWordWe(progWordWe),
    .progWordAddr(progWordAddr), .flashEraseStrobe(flashEraseStrobe),
    .eepromEraseStrobe(eepromEraseStrobe), .lockClearStrobe(lockClearStrobe));

//--- bench/ppfe_prog_model.sv
/*
  Parallel programmer model driving the front end's pins.
  Assumes its tasks are called one at a time by the testbench.
*/
`timescale 1ns/1ps
module ppfe_prog_model
(
    // Pacing clock
    input  wire logic       mclk,
    // Programmer pins
    output logic            loadStrobePin,
    output logic            actionSelectHi,
    output logic            actionSelectLo,
    output logic            byteSelectOne,
    output logic            pageLatchStrobe,
    output logic            writeStrobe_n,
    output logic [7:0]      dataIn
);
    // Idle pins at time zero
    initial
    begin
        loadStrobePin = 1'b0;
        {actionSelectHi, actionSelectLo} = 2'h3;
        byteSelectOne = 1'b0;
        pageLatchStrobe = 1'b0;
        writeStrobe_n = 1'b1;
        dataIn = 8'hA5;
    end

    // Pins move on falling edges only, four cycles apart
    task automatic hold();
        repeat (4) @(negedge mclk);
    endtask

    // Load a byte; the bus is inverted after release so a stale value is never seen
    task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
        @(negedge mclk);
        {actionSelectHi, actionSelectLo} = act;
        byteSelectOne = bs;
        dataIn = d;
        hold();
        loadStrobePin = 1'b1;
        hold();
        loadStrobePin = 1'b0;
        hold();
        dataIn = ~d;
        {actionSelectHi, actionSelectLo} = 2'h3;
    endtask

    // Write pulse with byte select low, or latch pulse with it high
    task automatic pulse(input logic wr);
        @(negedge mclk);
        byteSelectOne = !wr;
        hold();
        if (wr)
            writeStrobe_n = 1'b0;
        else
            pageLatchStrobe = 1'b1;
        hold();
        writeStrobe_n = 1'b1;
        pageLatchStrobe = 1'b0;
        hold();
    endtask
endmodule

//--- bench/ppfe_top_tb_top.sv
/*
  Self-checking testbench of the front end: loads, erase, page write.
  Assumes small count parameters so each operation ends within 200 cycles.
*/
`timescale 1ns/1ps
module ppfe_top_tb_top;
    logic        mclk;
    logic        rst_n;
    logic        clkEn;
    logic        eepromKeepFuse;
    logic        loadStrobePin, actionSelectHi, actionSelectLo, byteSelectOne;
    logic        pageLatchStrobe, writeStrobe_n;
    logic [7:0]  dataIn, commandByte, c;
    logic [15:0] addressWord, progWordData;
    logic [11:0] progWordAddr;
    logic        writeDoneFlag, progWordWe, flashEraseStrobe, eepromEraseStrobe, lockClearStrobe;
    logic [15:0] ed[32];
    logic [15:0] gotData[32];
    logic [6:0]  gotPage, pg;
    logic [3:0]  hn;
    int          num_errors, check_count, flashCnt, eepromCnt, lockCnt, wordCnt;

    ppfe_prog_model pm (.mclk(mclk), .loadStrobePin(loadStrobePin), .actionSelectHi(actionSelectHi),
        .actionSelectLo(actionSelectLo), .byteSelectOne(byteSelectOne),
        .pageLatchStrobe(pageLatchStrobe), .writeStrobe_n(writeStrobe_n), .dataIn(dataIn));

    ppfe_top #(.PAGE_CYCLES(64), .ERASE_CYCLES(40)) uut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
        .loadStrobePin(loadStrobePin), .actionSelectHi(actionSelectHi), .actionSelectLo(actionSelectLo),
        .byteSelectOne(byteSelectOne), .pageLatchStrobe(pageLatchStrobe), .writeStrobe_n(writeStrobe_n),
        .dataIn(dataIn), .eepromKeepFuse(eepromKeepFuse), .writeDoneFlag(writeDoneFlag),
        .commandByte(commandByte), .addressWord(addressWord), .progWordWe(progWordWe),
        .progWordAddr(progWordAddr), .progWordData(progWordData), .flashEraseStrobe(flashEraseStrobe),
        .eepromEraseStrobe(eepromEraseStrobe), .lockClearStrobe(lockClearStrobe));

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    // Record programmed words and count erase strobes; falling edge, where outputs have settled
    always @(negedge mclk)
    begin
        if (progWordWe === 1'b1)
        begin
            gotData[progWordAddr[4:0]] = progWordData;
            gotPage = progWordAddr[11:5];
            wordCnt++;
        end
        if (flashEraseStrobe === 1'b1) flashCnt++;
        if (eepromEraseStrobe === 1'b1) eepromCnt++;
        if (lockClearStrobe === 1'b1) lockCnt++;
    end

    // Expected loaded address: page bits straddle the two address bytes
    function automatic logic [15:0] exp_addr(input logic [3:0] h, input logic [6:0] p, input logic [4:0] w);
        return {h, p, w};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Bounded wait for ready; running out ends the run
    task automatic wait_ready();
        for (int i = 0; i < 200 && writeDoneFlag !== 1'b1; i++) @(negedge mclk);
        if (writeDoneFlag !== 1'b1)
        begin
            num_errors++;
            conclude();
        end
        else
            repeat (2) @(negedge mclk);     // Lets the monitor count the strobe that rides with ready
    endtask

    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        clkEn = 1'b1;
        eepromKeepFuse = 1'b0;
        {num_errors, check_count, flashCnt, eepromCnt, lockCnt, wordCnt} = '0;
        void'($urandom(61));
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        check(writeDoneFlag, 1);
        check(addressWord, 0);
        // Random commands, then an idle action that must leave the last one
        repeat (4)
        begin
            c = 8'($urandom);
            pm.load(2'h2, 0, c);
            check(commandByte, c);
        end
        pm.load(2'h3, 0, ~c);
        check(commandByte, c);
        // A strobe while the clock enable is low must leave the command byte unchanged
        clkEn = 1'b0;
        pm.load(2'h2, 0, ~c);
        clkEn = 1'b1;
        check(commandByte, c);
        // Erase with fuse low then high; a second write pulse while busy is ignored
        for (int k = 0; k < 2; k++)
        begin
            eepromKeepFuse = k[0];
            pm.load(2'h2, 0, 8'h80);
            pm.pulse(1);
            check(writeDoneFlag, 0);
            pm.pulse(1);
            wait_ready();
            check(flashCnt, k + 1);
            check(eepromCnt, 1);
            check(lockCnt, k + 1);
        end
        // Reset in mid-erase: busy ends at once and the lock clear never comes
        pm.load(2'h2, 0, 8'h80);
        pm.pulse(1);
        rst_n = 1'b0;
        @(negedge mclk);
        check(writeDoneFlag, 1);
        check(commandByte, 0);
        rst_n = 1'b1;
        repeat (60) @(negedge mclk);
        check(flashCnt, 3);
        check(lockCnt, 2);
        // No-operation command: write pulse does nothing
        pm.load(2'h2, 0, 8'h00);
        pm.pulse(1);
        check(writeDoneFlag, 1);
        // Two full pages at random page numbers
        for (int p = 0; p < 2; p++)
        begin
            pg = 7'($urandom);
            hn = 4'($urandom);
            pm.load(2'h2, 0, 8'h10);
            pm.load(2'h0, 1, {hn, pg[6:3]});
            for (int w = 0; w < 32; w++)
            begin
                // No all-ones word is drawn: an erased word needs no write, and this buffer keeps stale words
                ed[w] = 16'($urandom % 32'h0000FFFF);
                pm.load(2'h0, 0, {pg[2:0], w[4:0]});
                pm.load(2'h1, 0, ed[w][7:0]);
                pm.load(2'h1, 1, ed[w][15:8]);
                pm.pulse(0);
            end
            check(addressWord, exp_addr(hn, pg, 5'h1F));
            wordCnt = 0;
            pm.pulse(1);
            check(writeDoneFlag, 0);
            wait_ready();
            check(wordCnt, 32);
            check(gotPage, pg);
            for (int w = 0; w < 32; w++) check(gotData[w], ed[w]);
        end
        conclude();
    end
endmodule
